//--- hdl/ucg_clock_gen.sv
// Function
// - Async divisor: ten integer, six fraction bits.
// - Sync rate uses integer divisor bits only.
// - Rate is 64clk/(S*div) or clk/(2*int).
// - Samples per bit: 16, 8, or 2.
// - Fractional generator in asynchronous and reserved modes only.
// - Five clock generation modes supported.
// - Slave clock sampled; peer keeps below quarter.
// - Double speed doubles rate, eight samples.
// - Debug halt stops only when configured.
// - Drive enable output for RS-485 transmitter.
// - Receive input, two-way data, two-way clock.
// - Tick events exported to event routing.
// - One-wire mode shares the transmit pin.
`timescale 1ns/1ns
`default_nettype none
`include "ucg_regs.svh"

module ucg_clock_gen (
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire ucg_pkg::ucg_cfg_t cfg,
  input  wire logic              tx_enable,
  input  wire logic              tx_busy,
  input  wire logic              tx_data,
  input  wire logic              debug_halt,
  input  wire logic              rxd_in,
  input  wire logic              txd_in,
  output logic                   txd_out,
  output logic                   txd_oe_n,
  input  wire logic              sync_transfer_clock_in,
  output logic                   sync_transfer_clock_out,
  output logic                   sync_transfer_clock_oe_n,
  output logic                   rs485_drive_enable,
  output logic                   rx_line,
  output logic                   halted,
  output ucg_pkg::ucg_tick_t     ticks
);

  ucg_pkg::ucg_src_t  src;
  logic [9:0]         baud_int;
  logic [4:0]         spb_lim;
  logic               halt_now;
  logic [2:0]         sync1_r;
  logic [2:0]         sync2_r;
  logic [2:0]         pins_in;
  logic               xck_s;
  logic               xck_prev_r;
  logic [15:0]        acc_r;
  logic [15:0]        acc_nxt;
  logic [16:0]        acc_sum;
  logic [9:0]         half_r;
  logic [9:0]         half_nxt;
  logic               xck_r;
  logic               xck_nxt;
  logic [4:0]         spb_r;
  logic [4:0]         spb_nxt;
  ucg_pkg::ucg_tick_t tick_nxt;
  ucg_pkg::ucg_tick_t tick_r;
  logic               txd_out_nxt;
  logic               txd_oe_n_nxt;
  logic               xck_oe_n_nxt;
  logic               rx_line_nxt;
  logic               txd_out_r;
  logic               txd_oe_n_r;
  logic               xck_oe_n_r;
  logic               rs485_r;
  logic               rx_line_r;
  logic               halted_r;

  // Clock source and samples per bit follow from the mode fields.
  always_comb begin
    baud_int = cfg.baud[`UCG_BAUD_INT_MSB:`UCG_BAUD_INT_LSB];
    unique case (cfg.comm_mode_select)
      ucg_pkg::UCG_MODE_SYNC: begin
        src = cfg.sync_master ? ucg_pkg::UCG_SRC_MASTER : ucg_pkg::UCG_SRC_SLAVE;
      end
      ucg_pkg::UCG_MODE_MSPI: begin
        src = ucg_pkg::UCG_SRC_MASTER;
      end
      ucg_pkg::UCG_MODE_ASYNC,
      ucg_pkg::UCG_MODE_RSVD: begin
        src = ucg_pkg::UCG_SRC_FRAC;
      end
    endcase
    if (src != ucg_pkg::UCG_SRC_FRAC) begin
      spb_lim = `UCG_SPB_SYNC;
    end else if (cfg.rx_sampling_select == ucg_pkg::UCG_RX_DOUBLE_SPEED) begin
      spb_lim = `UCG_SPB_DOUBLE;
    end else begin
      spb_lim = `UCG_SPB_NORMAL;
    end
    halt_now = debug_halt & ~cfg.debug_run;
  end

  // Pin inputs cross in through two flops; only the second stage is read.
  // Each stage resets to the idle level of its pin, so that no false clock
  // edge is seen when reset lets go.
  assign pins_in = {sync_transfer_clock_in, txd_in, rxd_in};
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r    <= `UCG_SYNC_RST;
      sync2_r    <= `UCG_SYNC_RST;
      xck_prev_r <= `UCG_XCK_RST;
    end else begin
      sync1_r    <= pins_in;
      sync2_r    <= sync1_r;
      xck_prev_r <= sync2_r[2];
    end
  end
  assign xck_s = sync2_r[2];

  // Tick generation. The accumulator adds one clock (64 units of 1/64) per cycle
  // and fires when it reaches the divisor, so the remainder rolls into the
  // next period and no period is off by more than one clock.
  always_comb begin
    acc_sum  = {1'b0, acc_r} + `UCG_FRAC_ONE;
    acc_nxt  = acc_r;
    half_nxt = half_r;
    xck_nxt  = xck_r;
    spb_nxt  = spb_r;
    tick_nxt = '0;
    if (!halt_now) begin
      unique case (src)
        ucg_pkg::UCG_SRC_FRAC: begin
          if (cfg.baud != 16'h0000 && acc_sum >= {1'b0, cfg.baud}) begin
            tick_nxt.sample_tick = 1'b1;
            acc_nxt = 16'(acc_sum - {1'b0, cfg.baud});
          end else begin
            acc_nxt = acc_sum[15:0];
          end
        end
        ucg_pkg::UCG_SRC_MASTER: begin
          if (baud_int != 10'h000) begin
            if (half_r >= baud_int) begin
              half_nxt = `UCG_HALF_RST;
              xck_nxt  = ~xck_r;
              tick_nxt.sample_tick = 1'b1;
              tick_nxt.xck_rise    = ~xck_r;
              tick_nxt.xck_fall    = xck_r;
            end else begin
              half_nxt = half_r + 10'h001;
            end
          end
        end
        ucg_pkg::UCG_SRC_SLAVE: begin
          tick_nxt.xck_rise    = xck_s & ~xck_prev_r;
          tick_nxt.xck_fall    = ~xck_s & xck_prev_r;
          tick_nxt.sample_tick = xck_s ^ xck_prev_r;
        end
        default: begin
          tick_nxt = '0;
        end
      endcase
    end
    // One bit period is spb_lim sample ticks.
    if (tick_nxt.sample_tick) begin
      if (spb_r >= spb_lim - 5'h01) begin
        spb_nxt = `UCG_SPB_RST;
        tick_nxt.bit_tick = 1'b1;
      end else begin
        spb_nxt = spb_r + 5'h01;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      acc_r  <= `UCG_ACC_RST;
      half_r <= `UCG_HALF_RST;
      xck_r  <= 1'b0;
      spb_r  <= `UCG_SPB_RST;
      tick_r <= '0;
    end else begin
      acc_r  <= acc_nxt;
      half_r <= half_nxt;
      xck_r  <= xck_nxt;
      spb_r  <= spb_nxt;
      tick_r <= tick_nxt;
    end
  end

  // Pin drivers. An open-drain line only ever pulls low, which gives the
  // wired-AND behaviour on a shared one-wire bus.
  always_comb begin
    txd_out_nxt  = tx_data;
    txd_oe_n_nxt = ~(tx_enable & (~cfg.open_drain_enable | ~tx_data));
    xck_oe_n_nxt = (src != ucg_pkg::UCG_SRC_MASTER);
    rx_line_nxt  = cfg.one_wire ? sync2_r[1] : sync2_r[0];
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      txd_out_r  <= `UCG_PIN_RST;
      txd_oe_n_r <= `UCG_OE_N_RST;
      xck_oe_n_r <= `UCG_OE_N_RST;
      rs485_r    <= 1'b0;
      rx_line_r  <= `UCG_PIN_RST;
      halted_r   <= 1'b0;
    end else begin
      txd_out_r  <= txd_out_nxt;
      txd_oe_n_r <= txd_oe_n_nxt;
      xck_oe_n_r <= xck_oe_n_nxt;
      rs485_r    <= tx_busy;
      rx_line_r  <= rx_line_nxt;
      halted_r   <= halt_now;
    end
  end

  // The tick bundle also feeds the event routing network directly.
  assign ticks                    = tick_r;
  assign txd_out                  = txd_out_r;
  assign txd_oe_n                 = txd_oe_n_r;
  assign sync_transfer_clock_out  = xck_r;
  assign sync_transfer_clock_oe_n = xck_oe_n_r;
  assign rs485_drive_enable       = rs485_r;
  assign rx_line                  = rx_line_r;
  assign halted                   = halted_r;

  // Checking helpers: cycles since the last tick or clock toggle, and a
  // flag that says the gap covers a whole period under a steady setup.
  // A smaller divisor can leave the accumulator above it, which gives a
  // burst of early ticks; only a tick taken from a remainder below the
  // divisor opens a gap that the period check may judge.
  logic [15:0]       gap_r;
  logic [15:0]       gap_nxt;
  logic              gap_ok_r;
  logic              gap_ok_nxt;
  logic              acc_low_r;
  ucg_pkg::ucg_cfg_t cfg_prev_r;
  always_comb begin
    gap_nxt    = gap_r;
    gap_ok_nxt = gap_ok_r;
    if (cfg != cfg_prev_r || halt_now) begin
      gap_ok_nxt = 1'b0;
      gap_nxt    = 16'h0000;
    end else if (tick_r.sample_tick) begin
      gap_ok_nxt = acc_low_r | (src != ucg_pkg::UCG_SRC_FRAC);
      gap_nxt    = 16'h0001;
    end else if (gap_r != 16'hFFFF) begin
      gap_nxt = gap_r + 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      gap_r      <= 16'h0000;
      gap_ok_r   <= 1'b0;
      acc_low_r  <= 1'b1;
      cfg_prev_r <= '0;
    end else begin
      gap_r      <= gap_nxt;
      gap_ok_r   <= gap_ok_nxt;
      acc_low_r  <= (acc_r < cfg.baud);
      cfg_prev_r <= cfg;
    end
  end

  // Fractional ticks come every int or int+1 clocks.
  AST_FRAC_PERIOD: assert property (@(posedge clk) disable iff (rst)
    (tick_r.sample_tick && gap_ok_r && src == ucg_pkg::UCG_SRC_FRAC
      && cfg == cfg_prev_r && !halt_now)
    |-> (gap_r >= {6'h00, baud_int} && gap_r <= {6'h00, baud_int} + 16'h0001))
    else $error("fractional tick spacing outside divisor bounds");

  // Master clock toggles exactly every integer-divisor clocks.
  AST_SYNC_HALF: assert property (@(posedge clk) disable iff (rst)
    (tick_r.sample_tick && gap_ok_r && src == ucg_pkg::UCG_SRC_MASTER
      && cfg == cfg_prev_r && !halt_now)
    |-> gap_r == {6'h00, baud_int})
    else $error("master clock half period differs from integer divisor");

  // A bit tick only ever rides on a sample tick.
  AST_BIT_ON_SAMPLE: assert property (@(posedge clk) disable iff (rst)
    tick_r.bit_tick |-> tick_r.sample_tick)
    else $error("bit tick without sample tick");

  // Double speed: eight sample ticks per bit.
  AST_DOUBLE_SPB: assert property (@(posedge clk) disable iff (rst)
    (tick_nxt.sample_tick && spb_r == 5'h07 && src == ucg_pkg::UCG_SRC_FRAC
      && cfg.rx_sampling_select == ucg_pkg::UCG_RX_DOUBLE_SPEED)
    |=> tick_r.bit_tick)
    else $error("double speed bit did not end after eight samples");

  // Halt with run disabled stops all ticks.
  AST_HALT: assert property (@(posedge clk) disable iff (rst)
    (debug_halt && !cfg.debug_run) |=> !tick_r.sample_tick)
    else $error("tick issued while halted for debug");

  // Slave ticks follow synchronised clock edges by one cycle.
  AST_SLAVE_EDGE: assert property (@(posedge clk) disable iff (rst)
    (src == ucg_pkg::UCG_SRC_SLAVE && !halt_now && $rose(xck_s))
    |=> tick_r.xck_rise && tick_r.sample_tick)
    else $error("slave clock rise not turned into a tick");

  // Clock pin is driven in master modes only.
  AST_XCK_DIR: assert property (@(posedge clk) disable iff (rst)
    ##1 (sync_transfer_clock_oe_n == ($past(src) != ucg_pkg::UCG_SRC_MASTER)))
    else $error("clock pin direction does not match mode");

  // Drive enable follows the transmitter busy flag.
  AST_RS485: assert property (@(posedge clk) disable iff (rst)
    tx_busy |=> rs485_drive_enable)
    else $error("drive enable missing while transmitting");

  // One-wire receive follows the transmit pin three cycles on.
  AST_ONE_WIRE: assert property (@(posedge clk) disable iff (rst)
    (cfg.one_wire ##1 cfg.one_wire ##1 cfg.one_wire)
    |=> rx_line == $past(txd_in, 3))
    else $error("one-wire receive does not follow the transmit pin");

  // Open drain never drives the line high.
  AST_OPEN_DRAIN: assert property (@(posedge clk) disable iff (rst)
    ($past(cfg.open_drain_enable) && !txd_oe_n) |-> !txd_out)
    else $error("open-drain line driven high");

endmodule : ucg_clock_gen
`default_nettype wire

//--- hdl/ucg_regs.svh
`ifndef UCG_REGS_SVH
`define UCG_REGS_SVH

// Baud divisor layout: integer part above, fractional part below.
`define UCG_BAUD_W       16
`define UCG_BAUD_INT_MSB 15
`define UCG_BAUD_INT_LSB 6
`define UCG_FRAC_ONE     17'h00040

// Samples per bit for each clock source.
`define UCG_SPB_NORMAL   5'h10
`define UCG_SPB_DOUBLE   5'h08
`define UCG_SPB_SYNC     5'h02

// Reset values of the pin drivers and counters.
`define UCG_ACC_RST      16'h0000
`define UCG_HALF_RST     10'h001
`define UCG_SPB_RST      5'h00
`define UCG_PIN_RST      1'h1
`define UCG_OE_N_RST     1'h1
// Synchroniser reset: clock pin idles low, data pins idle high.
`define UCG_SYNC_RST     3'h3
`define UCG_XCK_RST      1'h0

`endif

//--- hdl/ucg_pkg.sv
`default_nettype none

package ucg_pkg;

  // Communication mode, in the order of its two-bit code.
  typedef enum logic [1:0] {
    UCG_MODE_ASYNC,
    UCG_MODE_SYNC,
    UCG_MODE_RSVD,
    UCG_MODE_MSPI
  } ucg_mode_t;

  // Receive sampling: sixteen or eight samples per bit.
  typedef enum logic {
    UCG_RX_NORMAL,
    UCG_RX_DOUBLE_SPEED
  } ucg_rx_samp_t;

  // Where the sample ticks come from.
  typedef enum logic [1:0] {
    UCG_SRC_FRAC,
    UCG_SRC_MASTER,
    UCG_SRC_SLAVE
  } ucg_src_t;

  typedef struct packed {
    ucg_mode_t    comm_mode_select;
    logic         sync_master;
    ucg_rx_samp_t rx_sampling_select;
    logic [15:0]  baud;
    logic         one_wire;
    logic         open_drain_enable;
    logic         debug_run;
  } ucg_cfg_t;

  typedef struct packed {
    logic sample_tick;
    logic bit_tick;
    logic xck_rise;
    logic xck_fall;
  } ucg_tick_t;

endpackage : ucg_pkg

`default_nettype wire

//--- verification/ucg_peer_model.sv
`timescale 1ns/1ns
`default_nettype none

module ucg_peer_model (
  input  wire logic clk,
  input  wire logic run,
  input  wire logic rxd_level,
  input  wire logic txd_out,
  input  wire logic txd_oe_n,
  input  wire logic clk_out,
  input  wire logic clk_oe_n,
  output logic      rxd_pin,
  output logic      txd_pin,
  output logic      xck_pin
);
  logic [2:0] div_r = 3'h0;
  logic       xck_r = 1'b0;

  // Slave clock with eight cycles per phase, well under a quarter of clk.
  // It stands still low whenever the peer is not asked to clock.
  always_ff @(posedge clk) begin
    if (!run) begin
      div_r <= 3'h0;
      xck_r <= 1'b0;
    end else begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7) begin
        xck_r <= ~xck_r;
      end
    end
  end

  // Pull-up on the shared data line; the clock pin belongs to whoever drives it.
  assign rxd_pin = rxd_level;
  assign txd_pin = txd_oe_n ? 1'b1 : txd_out;
  assign xck_pin = clk_oe_n ? xck_r : clk_out;
endmodule : ucg_peer_model

`default_nettype wire

//--- verification/tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic               clk = 1'b0;
  logic               rst;
  ucg_pkg::ucg_cfg_t  cfg;
  logic               tx_enable;
  logic               tx_busy;
  logic               tx_data;
  logic               debug_halt;
  logic               peer_run;
  logic               rxd_level;
  logic               rxd_pin;
  logic               txd_pin;
  logic               xck_pin;
  logic               txd_out;
  logic               txd_oe_n;
  logic               xck_out;
  logic               xck_oe_n;
  logic               rs485;
  logic               rx_line;
  logic               halted;
  ucg_pkg::ucg_tick_t ticks;
  int                 bad_count = 0;
  int                 n_tests = 0;
  int                 ns;
  int                 nb;

  always #4 clk = ~clk;

  ucg_clock_gen DUT (.clk(clk), .rst(rst), .cfg(cfg), .tx_enable(tx_enable),
    .tx_busy(tx_busy), .tx_data(tx_data), .debug_halt(debug_halt), .rxd_in(rxd_pin),
    .txd_in(txd_pin), .txd_out(txd_out), .txd_oe_n(txd_oe_n),
    .sync_transfer_clock_in(xck_pin), .sync_transfer_clock_out(xck_out),
    .sync_transfer_clock_oe_n(xck_oe_n), .rs485_drive_enable(rs485), .rx_line(rx_line),
    .halted(halted), .ticks(ticks));

  ucg_peer_model peer (.clk(clk), .run(peer_run), .rxd_level(rxd_level),
    .txd_out(txd_out), .txd_oe_n(txd_oe_n), .clk_out(xck_out), .clk_oe_n(xck_oe_n),
    .rxd_pin(rxd_pin), .txd_pin(txd_pin), .xck_pin(xck_pin));

  // Single exit point for both the normal end and the watchdog.
  task automatic conclude();
    $display("Checks made %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t bit got %b expected %b", $time, got, exp);
    end
  endtask : chk_bit

  task automatic chk_cnt(input int got, input int lo, input int hi);
    n_tests++;
    if (got < lo || got > hi) begin
      bad_count++;
      $display("CHECK FAILED t=%0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask : chk_cnt

  // Counts tick pulses; sampled 2 ns after each edge so registered pulses have landed.
  task automatic count(input int cyc);
    ns = 0;
    nb = 0;
    repeat (cyc) begin
      @(posedge clk);
      #2;
      ns += int'(ticks.sample_tick === 1'b1);
      nb += int'(ticks.bit_tick === 1'b1);
    end
  endtask : count

  // Configure a mode without reset, let it settle, then measure rates over 480 cycles.
  task automatic run_mode(input ucg_pkg::ucg_mode_t m, input logic mst,
                          input ucg_pkg::ucg_rx_samp_t rx, input logic [15:0] b,
                          input logic slv, input int es, input int eb, input logic eoe);
    @(posedge clk);
    #1;
    cfg = '{m, mst, rx, b, 1'b0, 1'b0, 1'b1};
    peer_run = slv;
    repeat (24) @(posedge clk);
    count(480);
    chk_cnt(ns, es - 2, es + 2);
    chk_cnt(nb, eb - 2, eb + 2);
    chk_bit(xck_oe_n, eoe);
  endtask : run_mode

  initial begin
    rst = 1'b1;
    cfg = '{ucg_pkg::UCG_MODE_ASYNC, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h0080, 1'b0, 1'b0,
            1'b1};
    // Data pin high and transmitter off until rate and mode are set.
    {tx_enable, tx_busy, tx_data, debug_halt, peer_run} = 5'h04;
    rxd_level = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk_bit(txd_oe_n, 1'b1);
    chk_bit(xck_oe_n, 1'b1);
    chk_bit(rs485, 1'b0);
    chk_bit(ticks.sample_tick, 1'b0);
    rst = 1'b0;
    // Rates for every clock source; 0x00A0 is 2.5 cycles per sample tick.
    run_mode(ucg_pkg::UCG_MODE_ASYNC, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h00A0, 1'b0, 192, 12,
             1'b1);
    run_mode(ucg_pkg::UCG_MODE_ASYNC, 1'b0, ucg_pkg::UCG_RX_DOUBLE_SPEED, 16'h00A0, 1'b0,
             192, 24, 1'b1);
    run_mode(ucg_pkg::UCG_MODE_RSVD, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h0080, 1'b0, 240, 15,
             1'b1);
    run_mode(ucg_pkg::UCG_MODE_SYNC, 1'b1, ucg_pkg::UCG_RX_NORMAL, 16'h00BF, 1'b0, 240, 120,
             1'b0);
    run_mode(ucg_pkg::UCG_MODE_MSPI, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h0080, 1'b0, 240, 120,
             1'b0);
    run_mode(ucg_pkg::UCG_MODE_SYNC, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h0080, 1'b1, 60, 30,
             1'b1);
    // Debug halt stops the ticks only when running in debug is not allowed.
    run_mode(ucg_pkg::UCG_MODE_ASYNC, 1'b0, ucg_pkg::UCG_RX_NORMAL, 16'h0080, 1'b0, 240, 15,
             1'b1);
    @(posedge clk);
    #1;
    debug_halt = 1'b1;
    cfg.debug_run = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(halted, 1'b1);
    count(100);
    chk_cnt(ns, 0, 0);
    @(posedge clk);
    #1;
    cfg.debug_run = 1'b1;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(halted, 1'b0);
    count(100);
    chk_cnt(ns, 48, 52);
    // Drive enable follows the transmitter one cycle later; the divisor
    // is left alone while a frame is in progress.
    @(posedge clk);
    #1;
    debug_halt = 1'b0;
    tx_busy = 1'b1;
    chk_bit(rs485, 1'b0);
    @(posedge clk);
    #1;
    chk_bit(rs485, 1'b1);
    tx_busy = 1'b0;
    @(posedge clk);
    #1;
    chk_bit(rs485, 1'b0);
    // Receive line source: separate pin, then the shared transmit pin.
    rxd_level = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(rx_line, 1'b0);
    // One-wire: line high, mode set and the transmitter enabled in the same step.
    cfg.one_wire = 1'b1;
    tx_enable = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(txd_oe_n, 1'b0);
    chk_bit(txd_out, 1'b1);
    chk_bit(rx_line, 1'b1);
    tx_data = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(txd_out, 1'b0);
    chk_bit(rx_line, 1'b0);
    // Open drain: a high bit releases the line to its pull-up.
    cfg.open_drain_enable = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(txd_oe_n, 1'b0);
    chk_bit(txd_out, 1'b0);
    tx_data = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk_bit(txd_oe_n, 1'b1);
    chk_bit(rx_line, 1'b1);
    conclude();
  end

  // Whole run needs about 3800 cycles; this cuts a hang well beyond that.
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : tb_top

`default_nettype wire
